// file: hw/rsm_pin_mux.v
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defines.vh"

module rsm_pin_mux
#(
  parameter BUS_DIV = `RSM_BUS_DIV
)
(
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // port a pins
  input  wire [7:0]  port_a_bits_in,
  output reg  [7:0]  port_a_bits_out,
  output reg  [7:0]  port_a_bits_oe,
  // port b pins
  input  wire [7:0]  port_b_bits_in,
  output reg  [7:0]  port_b_bits_out,
  output reg  [7:0]  port_b_bits_oe,
  // port e pins
  input  wire [7:0]  port_e_in,
  output reg  [7:0]  port_e_out,
  output reg  [7:0]  port_e_oe,
  output wire        osc_pullup_en,
  output wire        mode_pulldown_en,
  // port p pins 2..0
  input  wire [2:0]  port_p_in,
  output reg  [2:0]  port_p_out,
  output reg  [2:0]  port_p_oe,
  // analog port bit 7
  input  wire        analog_port_bit7,
  output reg         analog_bit7_analog_en,
  output reg         converter_ext_trigger,
  // external bus side of the core
  input  wire        ext_addr_phase,
  input  wire [15:0] ext_addr,
  input  wire [15:0] ext_wdata,
  input  wire        ext_data_drive,
  output reg  [15:0] ext_rdata,
  input  wire        cpu_bus_idle,
  input  wire        low_byte_strobe_n,
  output reg         low_half_tag_n,
  input  wire [1:0]  queue_track,
  // peripheral functions for port p
  input  wire [2:0]  pwm_out,
  input  wire [2:0]  serial_port_one_out,
  input  wire [2:0]  serial_port_one_oe,
  output reg  [2:0]  serial_port_one_in,
  output wire        key_wakeup_req,
  // captured configuration
  output wire        osc_colpitts_sel,
  output wire        osc_pierce_sel,
  output wire        mode_select_a,
  output wire        mode_select_b,
  output wire        expanded_mode
);

  ////////////////////////////////////////////////////////////////////////
  // strap capture

  wire osc_type_q;
  wire in_reset;

  rsm_strap_capture u_straps
  (
    .pclk             (pclk),
    .presetn          (presetn),
    .osc_type_strap   (port_e_in[7]),
    .mode_a_pin       (port_e_in[5]),
    .mode_b_pin       (port_e_in[6]),
    .osc_type_q       (osc_type_q),
    .mode_select_a_q  (mode_select_a),
    .mode_select_b_q  (mode_select_b),
    .in_reset         (in_reset),
    .osc_pullup_en    (osc_pullup_en),
    .mode_pulldown_en (mode_pulldown_en)
  );

  assign osc_colpitts_sel = osc_type_q;
  assign osc_pierce_sel   = ~osc_type_q;
  // any non-zero mode selection runs the external bus
  assign expanded_mode    = mode_select_a | mode_select_b;

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg [4:0]  ctrl_q;
  reg [15:0] porta_q;
  reg [15:0] portb_q;
  reg [15:0] porte_q;
  reg [18:0] portp_q;
  reg [2:0]  wake_q;
  reg [1:0]  analog_q;
  reg [2:0]  pin_p_prev_q;

  wire       wr_en;
  wire       rd_setup;
  wire       hit;
  reg [31:0] rd_data;

  function [1:0] pfn;
    input [18:0] cfg;
    input integer idx;
    begin
      pfn = cfg[8+2*idx +: 2];
    end
  endfunction

  assign wr_en    = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable;
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~hit;

  assign hit = (paddr == `RSM_OFF_CTRL)   || (paddr == `RSM_OFF_STRAP) ||
               (paddr == `RSM_OFF_PORTA)  || (paddr == `RSM_OFF_PORTB) ||
               (paddr == `RSM_OFF_PORTE)  || (paddr == `RSM_OFF_PORTP) ||
               (paddr == `RSM_OFF_WAKE)   || (paddr == `RSM_OFF_ANALOG) ||
               (paddr == `RSM_OFF_PINS);

  always @*
  begin
    rd_data = 32'h00000000;
    case (paddr)
      `RSM_OFF_CTRL:   rd_data = {27'h0000000, ctrl_q};
      `RSM_OFF_STRAP:  rd_data = {29'h00000000, mode_select_b,
                                  mode_select_a, osc_type_q};
      `RSM_OFF_PORTA:  rd_data = {16'h0000, porta_q};
      `RSM_OFF_PORTB:  rd_data = {16'h0000, portb_q};
      `RSM_OFF_PORTE:  rd_data = {16'h0000, porte_q};
      `RSM_OFF_PORTP:  rd_data = {13'h0000, portp_q};
      `RSM_OFF_WAKE:   rd_data = {29'h00000000, wake_q};
      `RSM_OFF_ANALOG: rd_data = {23'h000000, analog_port_bit7,
                                  6'h00, analog_q};
      `RSM_OFF_PINS:   rd_data = {5'h00, port_p_in, port_e_in,
                                  port_b_bits_in, port_a_bits_in};
      default:         rd_data = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata   <= 32'h00000000;
      ctrl_q   <= `RSM_CTRL_RST;
      porta_q  <= `RSM_PORT_RST;
      portb_q  <= `RSM_PORT_RST;
      porte_q  <= `RSM_PORT_RST;
      portp_q  <= `RSM_PORTP_RST;
      analog_q <= `RSM_ANALOG_RST;
    end
    else
    begin
      if (rd_setup)
        prdata <= rd_data;
      if (wr_en)
      begin
        case (paddr)
          `RSM_OFF_CTRL:   ctrl_q   <= pwdata[4:0];
          `RSM_OFF_PORTA:  porta_q  <= pwdata[15:0];
          `RSM_OFF_PORTB:  portb_q  <= pwdata[15:0];
          `RSM_OFF_PORTE:  porte_q  <= pwdata[15:0];
          `RSM_OFF_PORTP:  portp_q  <= pwdata[18:0];
          `RSM_OFF_ANALOG: analog_q <= pwdata[1:0];
          default:         ctrl_q   <= ctrl_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // key wakeup: falling edge on an enabled gpio input pin sets a sticky flag

  reg [2:0] wake_set;
  reg [2:0] wake_clr;
  integer   k;

  always @*
  begin
    wake_set = 3'h0;
    wake_clr = 3'h0;
    for (k = 0; k < 3; k = k + 1)
    begin
      wake_set[k] = portp_q[16+k] & pin_p_prev_q[k] & ~port_p_in[k] &
                    (pfn(portp_q, k) == `RSM_PFN_GPIO) & ~portp_q[3+k];
      wake_clr[k] = wr_en & (paddr == `RSM_OFF_WAKE) & pwdata[k];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_q       <= 3'h0;
      pin_p_prev_q <= 3'h7;
    end
    else
    begin
      pin_p_prev_q <= port_p_in;
      wake_q       <= (wake_q & ~wake_clr) | wake_set;
    end
  end

  assign key_wakeup_req = |wake_q;

  ////////////////////////////////////////////////////////////////////////
  // bus clock divider

  reg [7:0] div_cnt_q;
  reg       bus_clk_q;
  wire      div_tick;

  assign div_tick = (div_cnt_q == BUS_DIV[7:0] - 8'h01);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_q <= 8'h00;
      bus_clk_q <= 1'b0;
    end
    else if (div_tick)
    begin
      div_cnt_q <= 8'h00;
      bus_clk_q <= ~bus_clk_q;
    end
    else
      div_cnt_q <= div_cnt_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin multiplexing

  reg [7:0]  pa_d;
  reg [7:0]  pa_oe_d;
  reg [7:0]  pb_d;
  reg [7:0]  pb_oe_d;
  reg [7:0]  pe_d;
  reg [7:0]  pe_oe_d;
  reg [2:0]  pp_d;
  reg [2:0]  pp_oe_d;
  integer    j;

  always @*
  begin
    pa_d    = porta_q[7:0];
    pa_oe_d = porta_q[15:8];
    pb_d    = portb_q[7:0];
    pb_oe_d = portb_q[15:8];
    if (expanded_mode)
    begin
      pa_d    = ext_addr_phase ? ext_addr[15:8] : ext_wdata[15:8];
      pb_d    = ext_addr_phase ? ext_addr[7:0] : ext_wdata[7:0];
      pa_oe_d = {8{ext_addr_phase | ext_data_drive}};
      pb_oe_d = {8{ext_addr_phase | ext_data_drive}};
    end

    pe_d    = porte_q[7:0];
    pe_oe_d = porte_q[15:8];
    if (expanded_mode && ctrl_q[`RSM_CTRL_FREE])
    begin
      pe_d[7]    = cpu_bus_idle;
      pe_oe_d[7] = 1'b1;
    end
    if (ctrl_q[`RSM_CTRL_QUEUE])
    begin
      pe_d[6]    = queue_track[1];
      pe_d[5]    = queue_track[0];
      pe_oe_d[6] = 1'b1;
      pe_oe_d[5] = 1'b1;
    end
    if (ctrl_q[`RSM_CTRL_BCLK])
    begin
      pe_d[4]    = bus_clk_q;
      pe_oe_d[4] = 1'b1;
    end
    if (expanded_mode && ctrl_q[`RSM_CTRL_TAG])
      pe_oe_d[3] = 1'b0;
    else if (expanded_mode && ctrl_q[`RSM_CTRL_STRB])
    begin
      pe_d[3]    = low_byte_strobe_n;
      pe_oe_d[3] = 1'b1;
    end
    // straps must see the board level, not a driven one
    if (in_reset)
      pe_oe_d = 8'h00;

    pp_d    = portp_q[2:0];
    pp_oe_d = portp_q[5:3];
    for (j = 0; j < 3; j = j + 1)
    begin
      case (pfn(portp_q, j))
        `RSM_PFN_PWM:
        begin
          pp_d[j]    = pwm_out[j];
          pp_oe_d[j] = 1'b1;
        end
        `RSM_PFN_SPI:
        begin
          pp_d[j]    = serial_port_one_out[j];
          pp_oe_d[j] = serial_port_one_oe[j];
        end
        default:
        begin
          pp_d[j]    = portp_q[j];
          pp_oe_d[j] = portp_q[3+j];
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_a_bits_out       <= 8'h00;
      port_a_bits_oe        <= 8'h00;
      port_b_bits_out       <= 8'h00;
      port_b_bits_oe        <= 8'h00;
      port_e_out            <= 8'h00;
      port_e_oe             <= 8'h00;
      port_p_out            <= 3'h0;
      port_p_oe             <= 3'h0;
      ext_rdata             <= 16'h0000;
      low_half_tag_n        <= 1'b1;
      serial_port_one_in    <= 3'h0;
      analog_bit7_analog_en <= 1'b0;
      converter_ext_trigger <= 1'b0;
    end
    else
    begin
      port_a_bits_out    <= pa_d;
      port_a_bits_oe     <= pa_oe_d;
      port_b_bits_out    <= pb_d;
      port_b_bits_oe     <= pb_oe_d;
      port_e_out         <= pe_d;
      port_e_oe          <= pe_oe_d;
      port_p_out         <= pp_d;
      port_p_oe          <= pp_oe_d;
      ext_rdata          <= {port_a_bits_in, port_b_bits_in};
      low_half_tag_n     <= ~(expanded_mode & ctrl_q[`RSM_CTRL_TAG]) |
                            port_e_in[3];
      serial_port_one_in <= port_p_in;
      analog_bit7_analog_en <= analog_q[`RSM_AN_ANALOG];
      converter_ext_trigger <= analog_q[`RSM_AN_TRIG] &
                               analog_port_bit7;
    end
  end

endmodule // rsm_pin_mux

`default_nettype wire

// file: hw/rsm_defines.vh
`ifndef RSM_DEFINES_VH
`define RSM_DEFINES_VH

// register byte offsets
`define RSM_OFF_CTRL    12'h000
`define RSM_OFF_STRAP   12'h004
`define RSM_OFF_PORTA   12'h008
`define RSM_OFF_PORTB   12'h00c
`define RSM_OFF_PORTE   12'h010
`define RSM_OFF_PORTP   12'h014
`define RSM_OFF_WAKE    12'h018
`define RSM_OFF_ANALOG  12'h01c
`define RSM_OFF_PINS    12'h020

// control register fields
`define RSM_CTRL_FREE   0
`define RSM_CTRL_QUEUE  1
`define RSM_CTRL_BCLK   2
`define RSM_CTRL_STRB   3
`define RSM_CTRL_TAG    4

// strap status fields
`define RSM_ST_OSC      0
`define RSM_ST_MODE_SELECT_A     1
`define RSM_ST_MODE_SELECT_B     2

// port p function codes
`define RSM_PFN_GPIO    2'h0
`define RSM_PFN_PWM     2'h1
`define RSM_PFN_SPI     2'h2

// analog config fields
`define RSM_AN_TRIG     0
`define RSM_AN_ANALOG   1
`define RSM_AN_LEVEL    8

// reset values
`define RSM_CTRL_RST    5'h00
`define RSM_PORT_RST    16'h0000
`define RSM_PORTP_RST   19'h00000
`define RSM_ANALOG_RST  2'h0

// bus clock divider: pclk cycles per bus clock half period
`define RSM_BUS_DIV     4

`endif

// file: hw/rsm_strap_capture.v
`timescale 1ns/1ps
`default_nettype none

module rsm_strap_capture
(
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // strap pins
  input  wire       osc_type_strap,
  input  wire       mode_a_pin,
  input  wire       mode_b_pin,
  // captured configuration
  output reg        osc_type_q,
  output reg        mode_select_a_q,
  output reg        mode_select_b_q,
  output wire       in_reset,
  // pull devices
  output wire       osc_pullup_en,
  output wire       mode_pulldown_en
);

  reg in_reset_q;

  assign in_reset         = in_reset_q;
  assign osc_pullup_en    = in_reset_q;
  assign mode_pulldown_en = in_reset_q;

  // straps are caught at the first edge after reset release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_reset_q      <= 1'b1;
      osc_type_q      <= 1'b1;
      mode_select_a_q <= 1'b0;
      mode_select_b_q <= 1'b0;
    end
    else if (in_reset_q)
    begin
      in_reset_q      <= 1'b0;
      osc_type_q      <= osc_type_strap;
      mode_select_b_q <= mode_b_pin;
      mode_select_a_q <= mode_a_pin;
    end
  end

endmodule // rsm_strap_capture

`default_nettype wire

// file: tb/rsm_pin_mux_sva.sv
`timescale 1ns/1ps
`default_nettype none

module rsm_pin_mux_sva
#(
  parameter BUS_DIV = 4
)
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // pins
  input wire logic [7:0]  port_a_bits_out,
  input wire logic [7:0]  port_b_bits_out,
  input wire logic [7:0]  port_e_in,
  input wire logic [7:0]  port_e_out,
  input wire logic [7:0]  port_e_oe,
  input wire logic        osc_pullup_en,
  input wire logic        mode_pulldown_en,
  input wire logic        analog_port_bit7,
  input wire logic        converter_ext_trigger,
  // core side
  input wire logic        ext_addr_phase,
  input wire logic [15:0] ext_addr,
  input wire logic        cpu_bus_idle,
  input wire logic        low_byte_strobe_n,
  input wire logic [1:0]  queue_track,
  // captured configuration
  input wire logic        osc_colpitts_sel,
  input wire logic        osc_pierce_sel,
  input wire logic        mode_select_a,
  input wire logic        mode_select_b,
  input wire logic        expanded_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] gap_q;
  logic [1:0] seen_q;
  wire        bclk = port_e_out[4];

  // gap between bus clock edges; the first edges after enable are skipped
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      gap_q  <= 8'h00;
      seen_q <= 2'h0;
    end
    else
    begin
      gap_q  <= $changed(bclk) ? 8'h01 : gap_q + 8'h01;
      seen_q <= !port_e_oe[4] ? 2'h0 :
                ($changed(bclk) && seen_q != 2'h2) ? seen_q + 2'h1 : seen_q;
    end

  //////////////////////////////////////////////////////////////////////////////
  sequence s_rel;
    presetn && !$past(presetn);
  endsequence
  sequence s_bclk;
    port_e_oe[4] && seen_q == 2'h2 && $changed(bclk);
  endsequence

  strap_capture_a: assert property (
    s_rel |=> {osc_colpitts_sel, mode_select_b, mode_select_a}
              == $past(port_e_in[7:5]))
    else $error("strap capture");
  strap_hold_a: assert property (
    presetn && $past(presetn) && $past(presetn, 2)
    |-> $stable({osc_colpitts_sel, mode_select_b, mode_select_a}))
    else $error("strap changed");
  osc_kind_a: assert property (
    osc_pierce_sel != osc_colpitts_sel) else $error("osc select");
  pull_off_a: assert property (
    presetn && $past(presetn) |-> !osc_pullup_en && !mode_pulldown_en)
    else $error("pull left on");
  free_flag_a: assert property (
    expanded_mode && port_e_oe[7] && $past(port_e_oe[7])
    |-> port_e_out[7] == $past(cpu_bus_idle)) else $error("free flag");
  queue_out_a: assert property (
    &port_e_oe[6:5] |-> port_e_out[6:5] == $past(queue_track))
    else $error("queue track");
  bus_clock_a: assert property (
    s_bclk |-> gap_q == BUS_DIV) else $error("bus clock");
  strobe_a: assert property (
    expanded_mode && port_e_oe[3]
    |-> port_e_out[3] == $past(low_byte_strobe_n)) else $error("strobe");
  addr_out_a: assert property (
    expanded_mode && $past(expanded_mode) && $past(ext_addr_phase)
    |-> {port_a_bits_out, port_b_bits_out} == $past(ext_addr))
    else $error("address out");
  trigger_a: assert property (
    converter_ext_trigger |-> $past(analog_port_bit7)) else $error("trigger");
endmodule // rsm_pin_mux_sva

bind rsm_pin_mux rsm_pin_mux_sva #(.BUS_DIV(BUS_DIV)) i_rsm_pin_mux_sva (.*);

`default_nettype wire

// file: tb/rsm_strap_board.sv
`timescale 1ns/1ps
`default_nettype none

module rsm_strap_board
(
  // clock
  input  wire logic       pclk,
  // device side of port e
  input  wire logic [7:0] port_e_out,
  input  wire logic [7:0] port_e_oe,
  input  wire logic       osc_pullup_en,
  input  wire logic       mode_pulldown_en,
  // board resistors and bench drive
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  output var  logic [7:0] port_e_in
);
  logic [7:0] last_q = 8'h00;

  // an undriven pin without a pull never shows a stale level
  always_ff @(posedge pclk)
    last_q <= port_e_in;

  always_comb
    for (int i = 0; i < 8; i++)
      if (port_e_oe[i])
        port_e_in[i] = port_e_out[i];
      else if (drv_en[i])
        port_e_in[i] = drv_val[i];
      else if (i == 7 && osc_pullup_en)
        port_e_in[i] = 1'b1;
      else if ((i == 5 || i == 6) && mode_pulldown_en)
        port_e_in[i] = 1'b0;
      else
        port_e_in[i] = ~last_q[i];
endmodule // rsm_strap_board

`default_nettype wire

// file: tb/rsm_pin_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defines.vh"

module rsm_pin_mux_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  port_p_in = 3'h7;
  logic        analog_port_bit7 = 1'b0;
  logic [2:0]  pwm_out = 3'h0;
  logic [7:0]  b_en = 8'h60;
  logic [7:0]  b_val = 8'h00;
  logic [15:0] stim_q = 16'h0;
  int          error_cnt = 0;
  int          total_checks = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, osc_pullup_en, mode_pulldown_en;
  wire         analog_bit7_analog_en, converter_ext_trigger;
  wire         low_half_tag_n, key_wakeup_req, expanded_mode;
  wire         osc_colpitts_sel, osc_pierce_sel;
  wire  [7:0]  port_a_bits_out, port_a_bits_oe, port_e_in;
  wire  [7:0]  port_e_out, port_e_oe;
  wire  [2:0]  port_p_out, port_p_oe, serial_port_one_in;
  wire  [15:0] ext_rdata;

  rsm_pin_mux #(.BUS_DIV(2)) i_rsm_pin_mux (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port_a_bits_in(8'h3c), .port_a_bits_out,
    .port_a_bits_oe, .port_b_bits_in(8'hc3), .port_b_bits_out(),
    .port_b_bits_oe(), .port_e_in, .port_e_out, .port_e_oe,
    .osc_pullup_en, .mode_pulldown_en, .port_p_in, .port_p_out,
    .port_p_oe, .analog_port_bit7, .analog_bit7_analog_en,
    .converter_ext_trigger, .ext_addr_phase(stim_q[0]),
    .ext_addr({stim_q[7:0], ~stim_q[7:0]}), .ext_wdata(~stim_q),
    .ext_data_drive(stim_q[5]), .ext_rdata, .cpu_bus_idle(stim_q[1]),
    .low_byte_strobe_n(stim_q[2]), .low_half_tag_n,
    .queue_track(stim_q[4:3]), .pwm_out, .serial_port_one_out(3'h4),
    .serial_port_one_oe({1'b1, stim_q[6:5]}), .serial_port_one_in,
    .key_wakeup_req,
    .osc_colpitts_sel, .osc_pierce_sel, .mode_select_a(),
    .mode_select_b(), .expanded_mode);

  rsm_strap_board i_rsm_strap_board (
    .pclk, .port_e_out, .port_e_oe, .osc_pullup_en, .mode_pulldown_en,
    .drv_en(b_en), .drv_val(b_val), .port_e_in);

  always #2.5 pclk = ~pclk;

  always @(posedge pclk)
    stim_q <= stim_q + 16'h1;

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // returns {pslverr, prdata} taken at the edge that completes the access
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic do_reset(input logic [7:0] en, input logic [7:0] val);
    @(posedge pclk);
    presetn <= 1'b0;
    b_en    <= en;
    b_val   <= val;
    tick(4);
    chk({osc_pullup_en, mode_pulldown_en, port_e_oe}, 10'h300);
    presetn <= 1'b1;
    tick(3);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset(8'h60, 8'h00);
    rd(`RSM_OFF_STRAP, 33'h1);
    chk({osc_colpitts_sel, osc_pierce_sel, expanded_mode}, 3'h4);
    chk({osc_pullup_en, mode_pulldown_en}, 2'h0);
    wr(`RSM_OFF_PORTA, 32'hff5a);
    tick(2);
    chk({port_a_bits_oe, port_a_bits_out}, 16'hff5a);
    rd(`RSM_OFF_PORTA, 33'hff5a);
    chk(ext_rdata, 16'h3cc3);
    rd(12'h024, 33'h100000000);
    wr(`RSM_OFF_STRAP, 32'h6);
    rd(`RSM_OFF_STRAP, 33'h1);
    wr(`RSM_OFF_CTRL, 32'h6);
    tick(12);
    chk(port_e_oe[6:4], 3'h7);
    wr(`RSM_OFF_PORTP, 32'h12400);
    pwm_out <= 3'h2;
    tick(3);
    chk({port_p_oe, port_p_out}, 6'h36);
    port_p_in <= 3'h6;
    tick(4);
    chk(key_wakeup_req, 1'b1);
    chk(serial_port_one_in, 3'h6);
    wr(`RSM_OFF_WAKE, 32'h1);
    tick(2);
    chk(key_wakeup_req, 1'b0);
    wr(`RSM_OFF_ANALOG, 32'h1);
    analog_port_bit7 <= 1'b1;
    tick(3);
    chk(converter_ext_trigger, 1'b1);
    rd(`RSM_OFF_ANALOG, 33'h101);
    wr(`RSM_OFF_ANALOG, 32'h2);
    tick(3);
    chk({analog_bit7_analog_en, converter_ext_trigger}, 2'h2);
    do_reset(8'he0, 8'h60);
    rd(`RSM_OFF_STRAP, 33'h6);
    chk({osc_colpitts_sel, osc_pierce_sel, expanded_mode}, 3'h3);
    wr(`RSM_OFF_CTRL, 32'hf);
    tick(12);
    chk(port_e_oe[7:3], 5'h1f);
    wr(`RSM_OFF_CTRL, 32'h10);
    b_en <= 8'he8;
    tick(3);
    chk({port_e_oe[3], low_half_tag_n}, 2'h0);
    b_val <= 8'h68;
    tick(3);
    chk(low_half_tag_n, 1'b1);
    wrap_up;
  end

  initial
  begin
    repeat (3000) @(posedge pclk);
    error_cnt++;
    wrap_up;
  end
endmodule // rsm_pin_mux_tb

`default_nettype wire
